// ==== hw/general_config_regs_part.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "gen_cfg_params.svh"

module general_config_regs_part #(
  parameter logic [7:0] VERSION_CODE = 8'hA5, // arbitrary value
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port from the serial interface decoder
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // device pins sampled for the input state register and the node address increment
  input wire logic left_reference_step_pin,
  input wire logic right_reference_direction_pin,
  input wire logic encoder_b_config_pin,
  input wire logic encoder_a_config_pin,
  input wire logic driver_enable_low_pin,
  input wire logic encoder_index_config_pin,
  input wire logic step_source_select,
  input wire logic diag_comparator_state,
  input wire logic address_increment_pin,
  // interface mode from the device core
  input wire logic uart_mode,
  // motion controller position
  input wire logic [31:0] actual_position,
  // node addressing towards the uart
  output logic [7:0] node_address,
  output logic [6:0] reply_delay_bits,
  // serial-out configuration pin
  output logic serial_out_config_pin_o,
  output logic serial_out_config_pin_oe,
  // position compare
  output logic position_pulse,
  output logic second_diag_output,
  // nonvolatile memory
  output logic program_busy,
  output logic [7:0] otp_read_data
);

  // delay code to bit times; odd and even codes of a pair share a length
  function automatic logic [6:0] delay_bits(input logic [3:0] code);
    logic [6:0] pair;
    pair = {3'h0, code | `DELAY_ODD};
    delay_bits = 7'(pair * `BIT_TIMES_PER_STEP);
  endfunction

  function automatic logic hit(input logic [6:0] addr, input logic [6:0] off);
    hit = (addr == off);
  endfunction

  // pin synchronisers
  wire logic [`PIN_COUNT-1:0] pin_raw;
  logic [`PIN_COUNT-1:0] pin_meta_reg;
  logic [`PIN_COUNT-1:0] pin_sync_reg;

  assign pin_raw = {address_increment_pin, diag_comparator_state,
                    step_source_select, encoder_index_config_pin,
                    driver_enable_low_pin, encoder_a_config_pin,
                    encoder_b_config_pin, right_reference_direction_pin,
                    left_reference_step_pin};

  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g++) begin : gen_sync
      always_ff @(posedge clk) begin
        if (!resetn) begin
          pin_meta_reg[g] <= 1'b0;
          pin_sync_reg[g] <= 1'b0;
        end else begin
          pin_meta_reg[g] <= pin_raw[g];
          pin_sync_reg[g] <= pin_meta_reg[g];
        end
      end
    end
  endgenerate

  // register decode
  wire logic wr_node;
  wire logic wr_polarity;
  wire logic wr_match;
  wire logic wr_program;
  wire logic rd_input;
  wire logic rd_program;
  wire logic addr_ok;
  wire logic key_ok;
  wire logic prog_start;
  wire logic [7:0] wr_addr_field;
  wire logic [31:0] input_word;

  assign wr_node = reg_write && hit(reg_addr, `ADDR_NODE_CONFIG);
  assign wr_polarity = reg_write && hit(reg_addr, `ADDR_INPUT_STATE);
  assign wr_match = reg_write && hit(reg_addr, `ADDR_MATCH_VALUE);
  assign wr_program = reg_write && hit(reg_addr, `ADDR_PROGRAM_PORT);
  assign rd_input = reg_read && hit(reg_addr, `ADDR_INPUT_STATE);
  assign rd_program = reg_read && hit(reg_addr, `ADDR_PROGRAM_PORT);

  assign wr_addr_field = reg_wdata[`NODE_ADDR_MSB:`NODE_ADDR_LSB];
  assign addr_ok = (wr_addr_field <= `NODE_ADDR_MAX);

  assign key_ok = (reg_wdata[`PROG_KEY_MSB:`PROG_KEY_LSB] == `PROG_KEY);
  // a write while a bit is still burning is dropped, not queued
  assign prog_start = wr_program && key_ok && !program_busy;

  assign input_word = {VERSION_CODE, 16'h0000,
                       pin_sync_reg[`PIN_MSB:0]};

  // registers
  logic [7:0] node_reg;
  logic [3:0] delay_reg;
  logic polarity_reg;
  logic [31:0] match_reg;
  logic [31:0] rdata_reg;
  logic [7:0] eff_addr_reg;
  logic [6:0] delay_bits_reg;
  logic pin_o_reg;
  logic pin_oe_reg;
  logic pulse_reg;
  logic diag_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      node_reg <= `NODE_ADDR_RESET;
      delay_reg <= `DELAY_RESET;
    end else if (wr_node && addr_ok) begin
      node_reg <= wr_addr_field;
      delay_reg <= reg_wdata[`DELAY_MSB:`DELAY_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) polarity_reg <= `POLARITY_RESET;
    else if (wr_polarity) polarity_reg <= reg_wdata[`POLARITY_BIT];
  end

  always_ff @(posedge clk) begin
    if (!resetn) match_reg <= 32'h0000_0000;
    else if (wr_match) match_reg <= reg_wdata;
  end

  // reads return the snapshot
  // write-only registers read as zero, like unmapped offsets
  always_ff @(posedge clk) begin
    if (!resetn) rdata_reg <= 32'h0000_0000;
    else if (reg_read) rdata_reg <= rd_input ? input_word : 32'h0000_0000;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      eff_addr_reg <= `NODE_ADDR_RESET;
      delay_bits_reg <= delay_bits(`DELAY_RESET);
    end else begin
      eff_addr_reg <= node_reg + {7'h00, pin_sync_reg[`INCREMENT_BIT]};
      delay_bits_reg <= delay_bits(delay_reg);
    end
  end

  // the pin only drives in uart mode; in spi mode it is the data output
  // and belongs to the spi block
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_o_reg <= `POLARITY_RESET;
      pin_oe_reg <= 1'b0;
    end else begin
      pin_o_reg <= polarity_reg;
      pin_oe_reg <= uart_mode;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pulse_reg <= 1'b0;
      diag_reg <= 1'b0;
    end else begin
      pulse_reg <= (actual_position == match_reg);
      diag_reg <= (actual_position == match_reg);
    end
  end

  otp_program_engine #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_engine (
    .clk(clk),
    .resetn(resetn),
    .start(prog_start),
    .bit_sel(reg_wdata[`PROG_BIT_MSB:`PROG_BIT_LSB]),
    .byte_sel(reg_wdata[`PROG_BYTE_MSB:`PROG_BYTE_LSB]),
    .refresh(rd_program),
    .busy(program_busy),
    .read_data(otp_read_data)
  );

  assign reg_rdata = rdata_reg;
  assign node_address = eff_addr_reg;
  assign reply_delay_bits = delay_bits_reg;
  assign serial_out_config_pin_o = pin_o_reg;
  assign serial_out_config_pin_oe = pin_oe_reg;
  assign position_pulse = pulse_reg;
  assign second_diag_output = diag_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_addr_range: assert property (
    node_reg <= `NODE_ADDR_MAX)
    else $error("node address above limit");

  a_addr_reject: assert property (
    wr_node && !addr_ok |=> $stable(node_reg) && $stable(delay_reg))
    else $error("out of range node address accepted");

  sequence s_addr_steady;
    $stable(node_reg) && pin_sync_reg[`INCREMENT_BIT];
  endsequence

  a_addr_increment: assert property (
    s_addr_steady ##1 ($stable(node_reg) && pin_sync_reg[`INCREMENT_BIT])
      |=> node_address == $past(node_reg, 2) + 8'h01)
    else $error("incremented node address wrong");

  // odd code times eight, written as a shift so it does not copy the decode
  a_delay_table: assert property (
    $stable(delay_reg) [*2] |->
      reply_delay_bits == {delay_reg[3:1], 4'b1000})
    else $error("reply delay decode wrong");

  a_pin_snapshot: assert property (
    rd_input |=> reg_rdata[5:0] == $past(pin_sync_reg[5:0]))
    else $error("input state bits 0-5 wrong");

  a_mode_bit: assert property (
    rd_input |=> reg_rdata[`MODE_BIT] == $past(pin_sync_reg[`MODE_BIT]))
    else $error("step source bit wrong");

  a_comparator_bit: assert property (
    rd_input |=>
      reg_rdata[`COMPARATOR_BIT] == $past(pin_sync_reg[`COMPARATOR_BIT]))
    else $error("comparator bit wrong");

  a_version_code: assert property (
    rd_input |=> reg_rdata[`VERSION_MSB:`VERSION_LSB] == VERSION_CODE
      && reg_rdata[23:8] == 16'h0000)
    else $error("version code wrong");

  a_polarity_write: assert property (
    wr_polarity |=> ##1 serial_out_config_pin_o == $past(reg_wdata[0], 2))
    else $error("polarity not reflected on pin");

  a_polarity_reset: assert property (
    @(posedge clk) disable iff (1'b0)
    !resetn |=> polarity_reg && serial_out_config_pin_o)
    else $error("polarity did not reset high");

  a_match_pulse: assert property (
    (actual_position == match_reg) |=> position_pulse)
    else $error("pulse missing on match");

  a_mismatch_low: assert property (
    (actual_position != match_reg) |=> !position_pulse)
    else $error("pulse high on mismatch");

  a_diag_follow: assert property (
    second_diag_output == position_pulse)
    else $error("diag output differs from pulse");

  a_key_gate: assert property (
    wr_program && !key_ok |=> !program_busy || $past(program_busy))
    else $error("programming started without key");

  a_program_start: assert property (
    prog_start |=> program_busy)
    else $error("keyed write did not start programming");

  a_shared_write: assert property (
    wr_polarity |=> $stable(node_reg) && $stable(match_reg)
      && $stable(delay_reg))
    else $error("shared address write touched other registers");

  a_reset_values: assert property (
    @(posedge clk) disable iff (1'b0)
    !resetn |=> node_address == `NODE_ADDR_RESET && !program_busy)
    else $error("outputs not cleared by reset");

  a_node_write: assert property (
    wr_node && addr_ok |=> node_reg == $past(wr_addr_field)
      && delay_reg == $past(reg_wdata[`DELAY_MSB:`DELAY_LSB]))
    else $error("node configuration write lost");

  a_no_increment: assert property (
    !pin_sync_reg[`INCREMENT_BIT] |=> node_address == $past(node_reg))
    else $error("node address changed without increment pin");

  a_rdata_hold: assert property (
    !reg_read |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_pin_enable: assert property (
    1'b1 |=> serial_out_config_pin_oe == $past(uart_mode))
    else $error("serial-out pin enable does not follow uart mode");

  a_diag_match: assert property (
    (actual_position == match_reg) |=> second_diag_output)
    else $error("diag output missing on match");

  a_unmapped_zero: assert property (
    reg_read && !rd_input |=> reg_rdata == 32'h0000_0000)
    else $error("write-only offset returned data");

endmodule
`default_nettype wire

// ==== hw/gen_cfg_params.svh ====
`ifndef GEN_CFG_PARAMS_SVH
`define GEN_CFG_PARAMS_SVH

// register offsets on the internal register port
`define ADDR_NODE_CONFIG 7'h03
`define ADDR_INPUT_STATE 7'h04
`define ADDR_MATCH_VALUE 7'h05
`define ADDR_PROGRAM_PORT 7'h06

// node configuration fields
`define NODE_ADDR_LSB 0
`define NODE_ADDR_MSB 7
`define DELAY_LSB 8
`define DELAY_MSB 11
`define NODE_ADDR_MAX 8'hFD
`define NODE_ADDR_RESET 8'h00
`define DELAY_RESET 4'h0
`define DELAY_ODD 4'h1
`define BIT_TIMES_PER_STEP 7'h08

// input state and output polarity fields
`define PIN_COUNT 9
`define PIN_MSB 7
`define MODE_BIT 6
`define COMPARATOR_BIT 7
`define INCREMENT_BIT 8
`define VERSION_LSB 24
`define VERSION_MSB 31
`define POLARITY_BIT 0
`define POLARITY_RESET 1'b1

// nonvolatile programming fields
`define PROG_BIT_LSB 0
`define PROG_BIT_MSB 2
`define PROG_BYTE_LSB 4
`define PROG_BYTE_MSB 5
`define PROG_KEY_LSB 8
`define PROG_KEY_MSB 15
`define PROG_KEY 8'hBD
`define OTP_BYTES 4

// timing
`define CLK_HZ 25000000
`define MS_PER_S 1000
`define PROG_TIME_MS 10
`define PROG_CYCLES (`PROG_TIME_MS * `CLK_HZ / `MS_PER_S)

`endif

// ==== hw/gen_cfg_pkg.sv ====
package gen_cfg_pkg;

  typedef enum logic [2:0] {
    PROG_IDLE = 3'b001,
    PROG_BURN = 3'b010,
    PROG_DONE = 3'b100
  } prog_state_e;

  typedef logic [7:0] otp_byte_t;

endpackage

// ==== hw/otp_program_engine.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "gen_cfg_params.svh"

module otp_program_engine #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // requests
  input wire logic start,
  input wire logic [2:0] bit_sel,
  input wire logic [1:0] byte_sel,
  input wire logic refresh,
  // status
  output logic busy,
  output logic [7:0] read_data
);

  gen_cfg_pkg::prog_state_e state_reg, state_next;
  gen_cfg_pkg::otp_byte_t mem_reg [0:`OTP_BYTES-1];
  logic [31:0] count_reg;
  logic [2:0] bit_reg;
  logic [1:0] byte_reg;
  logic busy_reg;
  logic [7:0] read_reg;
  wire logic burn_over;

  assign burn_over = (count_reg == PROG_CYCLES - 32'd1);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      gen_cfg_pkg::PROG_IDLE: if (start) state_next = gen_cfg_pkg::PROG_BURN;
      gen_cfg_pkg::PROG_BURN: if (burn_over) state_next = gen_cfg_pkg::PROG_DONE;
      gen_cfg_pkg::PROG_DONE: state_next = gen_cfg_pkg::PROG_IDLE;
      default: state_next = gen_cfg_pkg::PROG_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= gen_cfg_pkg::PROG_IDLE;
      busy_reg <= 1'b0;
      count_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      busy_reg <= (state_next != gen_cfg_pkg::PROG_IDLE);
      count_reg <= (state_reg == gen_cfg_pkg::PROG_BURN) ?
                   count_reg + 32'h1 : 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < `OTP_BYTES; i++) mem_reg[i] <= 8'h00;
      bit_reg <= 3'h0;
      byte_reg <= 2'h0;
    end else begin
      if (state_reg == gen_cfg_pkg::PROG_IDLE && start) begin
        bit_reg <= bit_sel;
        byte_reg <= byte_sel;
      end
      if (state_reg == gen_cfg_pkg::PROG_DONE) mem_reg[byte_reg][bit_reg] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) read_reg <= 8'h00;
    else if (refresh) read_reg <= mem_reg[0];
  end

  assign busy = busy_reg;
  assign read_data = read_reg;

  sequence s_burn_end;
    state_reg == gen_cfg_pkg::PROG_BURN && burn_over;
  endsequence

  property p_single_bit;
    @(posedge clk) disable iff (!resetn)
    s_burn_end ##1 state_reg == gen_cfg_pkg::PROG_DONE
      |=> $countones(mem_reg[byte_reg] ^ $past(mem_reg[byte_reg])) <= 1
          && mem_reg[byte_reg][bit_reg];
  endproperty

  a_single_bit: assert property (p_single_bit)
    else $error("programming did not set exactly the selected bit");

  a_refresh_data: assert property (
    @(posedge clk) disable iff (!resetn)
    refresh |=> read_data == $past(mem_reg[0]))
    else $error("read-back not refreshed");

endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "gen_cfg_params.svh"

module host_model (
  // clock
  input wire logic clk,
  // register port towards the block
  output logic [6:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_write,
  output logic reg_read
);
  initial begin
    reg_addr = 7'h00;
    reg_wdata = 32'h0000_0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end

  // one strobe cycle; idle lines are inverted so stale data is never used
  task automatic access(input logic [6:0] a, input logic [31:0] d,
                        input logic w);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = w;
    reg_read = !w;
    @(negedge clk);
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // address in bits 7:0 and reply delay code in bits 11:8, both as given
  task automatic node_config(input logic [3:0] dly, input logic [7:0] a);
    access(`ADDR_NODE_CONFIG, {20'h00000, dly, a}, 1'b1);
  endtask

  // one bit, byte 00, key in 15:8
  task automatic program_bit(input logic [2:0] n, input logic [7:0] key);
    access(`ADDR_PROGRAM_PORT, {16'h0000, key, 4'h0, 1'b0, n}, 1'b1);
  endtask
endmodule
`default_nettype wire

// ==== tb/general_config_regs_part_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "gen_cfg_params.svh"

`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("unexpected %s exp %h got %h", nm, e, g); \
    end \
  end

module general_config_regs_part_tb;
  localparam logic [7:0] VER = 8'h5C; // arbitrary value
  typedef struct {string nm; int sel; logic [31:0] exp;} note_s;
  logic clk, resetn, inc, uart;
  logic [7:0] pins, a;
  logic [31:0] pos, x;
  wire logic [6:0] reg_addr;
  wire logic [31:0] reg_wdata, reg_rdata;
  wire logic reg_write, reg_read, pin_o, pin_oe, pulse, diag, busy;
  wire logic [7:0] node_address, otp_read_data;
  wire logic [6:0] reply_delay_bits;
  note_s notes[$];
  int err_count = 0;
  int check_count = 0;

  host_model H (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read));

  general_config_regs_part #(.VERSION_CODE(VER), .PROG_CYCLES(4)) DUT (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .left_reference_step_pin(pins[0]),
    .right_reference_direction_pin(pins[1]),
    .encoder_b_config_pin(pins[2]), .encoder_a_config_pin(pins[3]),
    .driver_enable_low_pin(pins[4]), .encoder_index_config_pin(pins[5]),
    .step_source_select(pins[6]), .diag_comparator_state(pins[7]),
    .address_increment_pin(inc), .uart_mode(uart),
    .actual_position(pos), .node_address(node_address),
    .reply_delay_bits(reply_delay_bits), .serial_out_config_pin_o(pin_o),
    .serial_out_config_pin_oe(pin_oe), .position_pulse(pulse),
    .second_diag_output(diag), .program_busy(busy),
    .otp_read_data(otp_read_data));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] seen(input int s);
    case (s)
      0: return reg_rdata;
      1: return {24'h000000, node_address};
      2: return {25'h0000000, reply_delay_bits};
      3: return {30'h00000000, pin_oe, pin_o};
      4: return {30'h00000000, diag, pulse};
      5: return {31'h00000000, busy};
      default: return {24'h000000, otp_read_data};
    endcase
  endfunction

  task automatic note(input string nm, input int s, input logic [31:0] e);
    notes.push_back('{nm, s, e});
  endtask

  task automatic settle(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic rd(input logic [6:0] ad);
    H.access(ad, 32'h0000_0000, 1'b0);
    settle(1);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) err_count++;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // scoreboard: oldest note against the outputs as they stand now
  initial begin
    note_s n;
    forever begin
      wait (notes.size() != 0);
      n = notes.pop_front();
      `CHK(n.nm, n.exp, seen(n.sel))
    end
  end

  initial begin
    #(40 * 20000);
    err_count++;
    stop_test();
  end

  initial begin
    resetn = 1'b0;
    inc = 1'b0;
    uart = 1'b0;
    pins = 8'h00;
    pos = 32'h0000_0000;
    void'($urandom(32'h7fa51646));
    settle(6);
    resetn = 1'b1;
    settle(1);
    note("node", 1, 32'h0); // reset address
    note("delay", 2, 32'h8); // reset delay
    note("pin", 3, 32'h1); // polarity high, not driven
    note("pulse", 4, 32'h3); // zero position equals zero compare
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      a = 8'($urandom_range(253));
      H.node_config(c[3:0], a);
      settle(2);
      note("node", 1, {24'h0, a}); // programmed address
      note("delay", 2, (c < 2) ? 8 : 8 * (c | 1)); // delay code
    end
    H.node_config(4'h5, 8'hFE);
    settle(2);
    note("node", 1, {24'h0, a}); // 254 refused
    note("delay", 2, 32'd120); // whole write dropped
    H.node_config(4'h2, 8'hFD);
    inc = 1'b1;
    settle(5);
    note("node", 1, 32'hFE); // incremented address
    inc = 1'b0;
    settle(5);
    note("node", 1, 32'hFD); // increment released
    $display("test node done");
    for (int i = 0; i < 4; i++) begin
      pins = 8'($urandom);
      settle(4);
      rd(`ADDR_INPUT_STATE);
      note("input", 0, {VER, 16'h0, pins});
    end
    rd(7'h7F);
    note("unmapped", 0, 32'h0); // nothing returned
    uart = 1'b1;
    H.access(`ADDR_INPUT_STATE, 32'hFFFF_FFFE, 1'b1);
    settle(2);
    note("pin", 3, 32'h2); // driven, polarity low
    rd(`ADDR_INPUT_STATE);
    note("input", 0, {VER, 16'h0, pins}); // write left pins alone
    resetn = 1'b0;
    settle(1);
    resetn = 1'b1;
    settle(1);
    note("pin", 3, 32'h3); // reset back to one
    note("node", 1, 32'h0); // reset again
    $display("test input and polarity done");
    x = $urandom;
    pos = ~x;
    H.access(`ADDR_MATCH_VALUE, x, 1'b1);
    note("pulse", 4, 32'h0); // positions differ
    pos = x;
    settle(2);
    note("pulse", 4, 32'h3); // equal positions
    settle(1);
    note("pulse", 4, 32'h3); // copy on diag
    pos = x + 32'h1;
    settle(1);
    note("pulse", 4, 32'h0); // mismatch drops
    settle(1);
    note("pulse", 4, 32'h0); // diag drops too
    $display("test compare done");
    H.program_bit(3'h3, 8'h00);
    settle(1);
    note("busy", 5, 32'h0); // no key, no burn
    H.program_bit(3'h3, `PROG_KEY);
    settle(1);
    note("busy", 5, 32'h1); // burning one bit
    H.program_bit(3'h0, `PROG_KEY);
    wait_idle();
    H.program_bit(3'h7, `PROG_KEY);
    wait_idle();
    note("otp", 6, 32'h0); // stale until read
    rd(`ADDR_PROGRAM_PORT);
    note("rdata", 0, 32'h0); // port reads zero
    note("otp", 6, 32'h88); // bits 3 and 7 only
    $display("test program done");
    wait (notes.size() == 0);
    stop_test();
  end
endmodule
`default_nettype wire
